/* logic/st_mf_pkg.sv */
// package: register map, field layout and line-side carrier types of the multiframe buffer
package st_mf_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [5:0] IDX_CTRL   = 6'h10;  // multiframing control
    localparam logic [5:0] IDX_RX_Q   = 6'h12;  // rx_q_channel_data, read only
    localparam logic [5:0] IDX_TX_S   = 6'h13;  // tx_s_subchannel_data, write only
    localparam logic [5:0] IDX_EVT    = 6'h16;  // sticky event status, read only
    localparam logic [5:0] IDX_EVT_CL = 6'h17;  // event clear, write one to clear
    localparam logic [5:0] IDX_EVT_EN = 6'h18;  // event interrupt enable

    // ****************************************************************
    // field positions and widths
    // ****************************************************************
    localparam int          ADDR_W       = 8;
    localparam int          CTRL_MF_EN   = 0;    // multiframing_enable bit
    localparam int          EVT_S_RDY    = 0;    // s_data_ready_flag bit
    localparam int          EVT_NEW_Q    = 1;    // new_q_message_flag bit
    localparam int          EVT_W        = 2;
    localparam int          NIB_W        = 4;
    localparam int          NUM_SUB      = 5;
    localparam int          S_BITS       = NIB_W * NUM_SUB;
    localparam logic [2:0]  SUB_LAST     = 3'h5; // pointer value once all slots filled
    localparam logic [1:0]  Q_LAST_BIT   = 2'h3; // index of the fourth q bit

    // ****************************************************************
    // reset and fill values
    // ****************************************************************
    localparam logic [3:0]  Q_RESET      = 4'hf;
    localparam logic [3:0]  Q_DISABLED   = 4'hf;
    localparam logic [19:0] S_FILL       = 20'hfffff;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // ****************************************************************
    // line-side carriers
    // ****************************************************************
    typedef struct packed {
        logic strobe;  // one q bit is present this cycle
        logic first;   // this q bit is the first of a multiframe
        logic data;    // q bit value
    } q_line_t;

    typedef struct packed {
        logic mf_start; // outgoing multiframe begins, pulse
        logic req;      // line takes the next s bit, pulse
    } s_line_t;

endpackage : st_mf_pkg

/* logic/st_multiframe_qs_buffer.sv */
// module: q-channel capture and s-subchannel transmit buffer with axi4-lite registers
//
// Function
// - with multiframing on, q register shows four q bits of latest complete multiframe
// - with multiframing off, all four q register bits read as one
// - new-q-message flag rises whenever a fresh q message is captured
// - first received q bit lands in bit 3, last in bit 0
// - with multiframing on, written nibbles go out on the five s subchannels
// - with multiframing off, outgoing s data bits are held at zero
// - with multiframing on, s-data-ready flag rises at each multiframe start, when the s register can take a new set
// - at most five nibbles per ready event, each to next free subchannel
// - subchannels left without written data send all ones
// - each s nibble goes out bit 3 first, bit 0 last
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module st_multiframe_qs_buffer (
    // clock and reset
    input  wire  logic                          aclk,
    input  wire  logic                          aresetn,
    // axi4-lite write address
    input  wire  logic [st_mf_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire  logic [2:0]                    s_axi_awprot,
    input  wire  logic                          s_axi_awvalid,
    output logic                                s_axi_awready,
    // axi4-lite write data
    input  wire  logic [31:0]                   s_axi_wdata,
    input  wire  logic [3:0]                    s_axi_wstrb,
    input  wire  logic                          s_axi_wvalid,
    output logic                                s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire  logic                          s_axi_bready,
    // axi4-lite read address
    input  wire  logic [st_mf_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire  logic [2:0]                    s_axi_arprot,
    input  wire  logic                          s_axi_arvalid,
    output logic                                s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire  logic                          s_axi_rready,
    // line side, same clock domain
    input  wire  st_mf_pkg::q_line_t            q_line,
    input  wire  st_mf_pkg::s_line_t            s_line,
    output logic                                s_bit,
    // interrupt
    output logic                                irq
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic                                mf_en_r;
    logic [3:0]                          q_shift_r;
    logic [1:0]                          q_cnt_r;
    logic [3:0]                          q_hold_r;
    logic [3:0]                          q_view;
    logic                                q_capture;
    logic [st_mf_pkg::S_BITS-1:0]        pend_r;
    logic [st_mf_pkg::S_BITS-1:0]        act_r;
    logic [st_mf_pkg::S_BITS-1:0]        act_nxt;
    logic [2:0]                          wr_ptr_r;
    logic                                s_bit_r;
    logic [st_mf_pkg::EVT_W-1:0]         evt_r;
    logic [st_mf_pkg::EVT_W-1:0]         evt_en_r;
    logic [st_mf_pkg::EVT_W-1:0]         evt_set;
    logic [st_mf_pkg::EVT_W-1:0]         evt_clr;
    logic                                aw_got_r;
    logic                                w_got_r;
    logic [5:0]                          aw_idx_r;
    logic [31:0]                         wdata_r;
    logic [3:0]                          wstrb_r;
    logic                                wr_fire;
    logic                                wr_lane0;
    logic                                wr_s_push;
    logic                                bvalid_r;
    logic [1:0]                          bresp_r;
    logic                                rvalid_r;
    logic [1:0]                          rresp_r;
    logic [31:0]                         rdata_r;
    logic [5:0]                          ar_idx;
    logic [31:0]                         rd_data;
    logic                                rd_hit;
    logic                                wr_hit;

    // ****************************************************************
    // axi4-lite write channel
    // ****************************************************************

    // address and data are taken in either order, one write at a time
    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready  = !w_got_r && !bvalid_r;
    assign wr_fire       = aw_got_r && w_got_r && !bvalid_r;
    assign wr_lane0      = wr_fire && wstrb_r[0];
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    // write address decode
    always_comb begin
        unique case (aw_idx_r)
            st_mf_pkg::IDX_CTRL,
            st_mf_pkg::IDX_RX_Q,
            st_mf_pkg::IDX_TX_S,
            st_mf_pkg::IDX_EVT,
            st_mf_pkg::IDX_EVT_CL,
            st_mf_pkg::IDX_EVT_EN: wr_hit = 1'b1;
            default:               wr_hit = 1'b0;
        endcase
    end

    // latch address and data, issue the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            aw_idx_r <= 6'h00;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r  <= st_mf_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_idx_r <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? st_mf_pkg::RESP_OKAY : st_mf_pkg::RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // axi4-lite read channel
    // ****************************************************************
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign ar_idx        = s_axi_araddr[7:2];

    // read mux, write-only registers read as zero
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (ar_idx)
            st_mf_pkg::IDX_CTRL:   rd_data[st_mf_pkg::CTRL_MF_EN] = mf_en_r;
            st_mf_pkg::IDX_RX_Q:   rd_data[3:0] = q_view;
            st_mf_pkg::IDX_TX_S:   rd_data = 32'h0000_0000;
            st_mf_pkg::IDX_EVT:    rd_data[st_mf_pkg::EVT_W-1:0] = evt_r;
            st_mf_pkg::IDX_EVT_CL: rd_data = 32'h0000_0000;
            st_mf_pkg::IDX_EVT_EN: rd_data[st_mf_pkg::EVT_W-1:0] = evt_en_r;
            default:               rd_hit = 1'b0;
        endcase
    end

    // registered read answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= st_mf_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_data;
            rresp_r  <= rd_hit ? st_mf_pkg::RESP_OKAY : st_mf_pkg::RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ****************************************************************
    // control and enable registers
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mf_en_r  <= 1'b0;
            evt_en_r <= '0;
        end else if (wr_lane0) begin
            if (aw_idx_r == st_mf_pkg::IDX_CTRL) begin
                mf_en_r <= wdata_r[st_mf_pkg::CTRL_MF_EN];
            end
            if (aw_idx_r == st_mf_pkg::IDX_EVT_EN) begin
                evt_en_r <= wdata_r[st_mf_pkg::EVT_W-1:0];
            end
        end
    end

    // ****************************************************************
    // receive q channel
    // ****************************************************************

    // fourth q bit of a multiframe completes the message
    assign q_capture = mf_en_r && q_line.strobe && !q_line.first
                       && (q_cnt_r == st_mf_pkg::Q_LAST_BIT);

    // shift order, first bit ends in bit 3
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_shift_r <= st_mf_pkg::Q_RESET;
            q_cnt_r   <= 2'h0;
        end else if (q_line.strobe) begin
            q_shift_r <= {q_shift_r[2:0], q_line.data};
            q_cnt_r   <= q_line.first ? 2'h1 : 2'(q_cnt_r + 2'h1);
        end
    end

    // hold latest complete message, overwritten by the next one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_hold_r <= st_mf_pkg::Q_RESET;
        end else if (q_capture) begin
            q_hold_r <= {q_shift_r[2:0], q_line.data};
        end
    end

    // forced ones while multiframing is off
    assign q_view = mf_en_r ? q_hold_r : st_mf_pkg::Q_DISABLED;

    // ****************************************************************
    // transmit s subchannels
    // ****************************************************************

    // nibbles only accepted while on and a slot is free
    assign wr_s_push = wr_lane0 && (aw_idx_r == st_mf_pkg::IDX_TX_S) && mf_en_r
                       && (s_line.mf_start || (wr_ptr_r != st_mf_pkg::SUB_LAST));

    // successive nibbles fill the next free slot
    // untouched slots keep the all-ones fill
    // pointer restarts when a new set is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_r   <= st_mf_pkg::S_FILL;
            wr_ptr_r <= 3'h0;
        end else if (s_line.mf_start && mf_en_r) begin
            pend_r   <= st_mf_pkg::S_FILL;
            wr_ptr_r <= 3'h0;
            if (wr_s_push) begin
                pend_r[19:16] <= wdata_r[3:0];
                wr_ptr_r      <= 3'h1;
            end
        end else if (wr_s_push) begin
            pend_r[5'd19 - {wr_ptr_r, 2'b00} -: 4] <= wdata_r[3:0];
            wr_ptr_r <= 3'(wr_ptr_r + 3'h1);
        end
    end

    // multiframe start hands the pending set to the line
    assign act_nxt = (s_line.mf_start && mf_en_r) ? pend_r : act_r;

    // zero on the line while multiframing is off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_r   <= st_mf_pkg::S_FILL;
            s_bit_r <= 1'b0;
        end else if (!mf_en_r) begin
            act_r   <= st_mf_pkg::S_FILL;
            s_bit_r <= 1'b0;
        end else if (s_line.req) begin
            s_bit_r <= act_nxt[19];
            act_r   <= {act_nxt[18:0], 1'b1};
        end else begin
            act_r   <= act_nxt;
        end
    end

    assign s_bit = s_bit_r;

    // ****************************************************************
    // events and interrupt
    // ****************************************************************
    assign evt_set[st_mf_pkg::EVT_NEW_Q] = q_capture;
    assign evt_set[st_mf_pkg::EVT_S_RDY] = s_line.mf_start && mf_en_r;
    assign evt_clr = (wr_lane0 && aw_idx_r == st_mf_pkg::IDX_EVT_CL)
                     ? wdata_r[st_mf_pkg::EVT_W-1:0] : '0;

    // sticky flags, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_r <= '0;
        end else begin
            evt_r <= (evt_r & ~evt_clr) | evt_set;
        end
    end

    assign irq = |(evt_r & evt_en_r);

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_q_forced_ones: assert property (@(posedge aclk) disable iff (!aresetn)
        !mf_en_r |-> q_view == 4'hf)
        else $error("q register not all ones while multiframing off");

    a_q_bit_order: assert property (@(posedge aclk) disable iff (!aresetn)
        q_capture |=> q_hold_r == {$past(q_shift_r[2:0]), $past(q_line.data)})
        else $error("q bits captured in wrong order");

    a_q_latest_msg: assert property (@(posedge aclk) disable iff (!aresetn)
        mf_en_r && !q_capture |=> q_hold_r == $past(q_hold_r))
        else $error("q register changed without a complete message");

    a_new_q_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        q_capture |=> evt_r[st_mf_pkg::EVT_NEW_Q])
        else $error("new q flag not raised on capture");

    a_s_ready_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        s_line.mf_start && mf_en_r |=> evt_r[st_mf_pkg::EVT_S_RDY])
        else $error("s ready flag not raised at multiframe start");

    a_ptr_restart: assert property (@(posedge aclk) disable iff (!aresetn)
        s_line.mf_start && mf_en_r && !wr_s_push |=> wr_ptr_r == 3'h0)
        else $error("s write pointer did not restart");

    a_five_max: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ptr_r == 3'h5 && !s_line.mf_start |=> wr_ptr_r == 3'h5 && pend_r == $past(pend_r))
        else $error("more than five nibbles accepted");

    a_pad_ones: assert property (@(posedge aclk) disable iff (!aresetn)
        s_line.mf_start && mf_en_r && !wr_s_push |=> pend_r == 20'hfffff)
        else $error("empty subchannels not filled with ones");

    a_s_zero_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !mf_en_r |=> !s_bit_r)
        else $error("s bit not zero while multiframing off");

    a_s_msb_first: assert property (@(posedge aclk) disable iff (!aresetn)
        mf_en_r && s_line.req && !s_line.mf_start |=> s_bit_r == $past(act_r[19]))
        else $error("s bit not taken from the nibble msb");

    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        q_capture && evt_en_r[st_mf_pkg::EVT_NEW_Q] && !wr_lane0 |=> irq)
        else $error("interrupt not raised by an enabled new q flag");

endmodule : st_multiframe_qs_buffer

`default_nettype wire

/* sim/te_line_model.sv */
// terminal equipment model: sends q bits, requests and collects s bits
`timescale 1ns/10ps
`default_nettype none

module te_line_model (
    // clock
    input  wire logic              aclk,
    // line side
    output var st_mf_pkg::q_line_t q_line,
    output var st_mf_pkg::s_line_t s_line,
    input  wire logic              s_bit
);
    // ****************************************************************
    // idle line at time zero
    // ****************************************************************
    initial begin
        q_line = '0;
        s_line = '0;
    end

    // ****************************************************************
    // q message and s frame
    // ****************************************************************
    // q1 goes first
    task automatic send_q(input logic [3:0] nib);
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            q_line <= '{strobe: 1'b1, first: (i == 0), data: nib[3-i]};
        end
        @(posedge aclk);
        q_line <= '{strobe: 1'b0, first: 1'b0, data: ~nib[0]}; // stale data inverted
    endtask : send_q

    // bit 19 is the first taken
    task automatic send_frame(output logic [19:0] got);
        @(posedge aclk);
        s_line <= '{mf_start: 1'b1, req: 1'b0};
        @(posedge aclk);
        s_line <= '0;
        for (int i = 19; i >= 0; i--) begin
            @(posedge aclk);
            s_line <= '{mf_start: 1'b0, req: 1'b1};
            @(posedge aclk);
            s_line <= '0;
            @(posedge aclk);
            got[i] = s_bit; // bit settled one edge after the request
        end
    endtask : send_frame
endmodule : te_line_model

`default_nettype wire

/* sim/test_st_multiframe_qs_buffer.sv */
// self-checking bench of the multiframe q/s buffer
`timescale 1ns/10ps
`default_nettype none

module test_st_multiframe_qs_buffer;
    localparam logic [7:0] A_CTRL = {st_mf_pkg::IDX_CTRL, 2'h0};
    localparam logic [7:0] A_Q    = {st_mf_pkg::IDX_RX_Q, 2'h0};
    localparam logic [7:0] A_S    = {st_mf_pkg::IDX_TX_S, 2'h0};
    localparam logic [7:0] A_EVT  = {st_mf_pkg::IDX_EVT, 2'h0};
    localparam logic [7:0] A_CLR  = {st_mf_pkg::IDX_EVT_CL, 2'h0};
    localparam logic [7:0] A_EN   = {st_mf_pkg::IDX_EVT_EN, 2'h0};
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, s_bit, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    st_mf_pkg::q_line_t q_line;
    st_mf_pkg::s_line_t s_line;
    int bad_count = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'd77940;

    // ****************************************************************
    // design and line partner
    // ****************************************************************
    st_multiframe_qs_buffer dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .q_line(q_line), .s_line(s_line), .s_bit(s_bit), .irq(irq)
    );
    te_line_model te_u (.aclk(aclk), .q_line(q_line), .s_line(s_line), .s_bit(s_bit));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // unfilled subchannels stay at the ones fill
    function automatic logic [19:0] exp_s(input logic [3:0] n [5], input int k);
        logic [19:0] e;
        e = st_mf_pkg::S_FILL;
        for (int i = 0; i < 5; i++)
            if (i < k) e[19-4*i -: 4] = n[i];
        return e;
    endfunction : exp_s

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one edge passes first so no strobe is set twice in one time step
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // ****************************************************************
    // clock and watchdog
    // ****************************************************************
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        end_sim();
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [19:0] got;
        logic [3:0]  nib [5];
        logic [3:0]  v;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb   = 4'hf;
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(A_Q, d, r);
        chk(d, 32'hf);
        axi_rd(8'h04, d, r);
        chk(r, st_mf_pkg::RESP_SLVERR);
        axi_wr(8'h04, 32'h1, r);
        chk(r, st_mf_pkg::RESP_SLVERR);
        te_u.send_q(4'h0);
        axi_rd(A_Q, d, r);
        chk(d, 32'hf);
        axi_wr(A_S, 32'h0, r);
        te_u.send_frame(got);
        chk(got, 20'h0);
        $display("test reset_and_disabled done");
        axi_wr(A_CTRL, 32'h1, r);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            v = (i == 0) ? 4'h8 : seed[3:0];
            te_u.send_q(v);
            // read right after the new-q event
            axi_rd(A_Q, d, r);
            chk(d, {28'h0, v});
            axi_rd(A_EVT, d, r);
            chk(d[st_mf_pkg::EVT_NEW_Q], 1'b1);
            axi_wr(A_CLR, 32'h3, r);
        end
        axi_wr(A_Q, 32'h0, r);
        chk(r, st_mf_pkg::RESP_OKAY);
        axi_rd(A_Q, d, r);
        chk(d, {28'h0, v});
        $display("test q_capture done");
        te_u.send_frame(got);
        axi_rd(A_EVT, d, r);
        chk(d[st_mf_pkg::EVT_S_RDY], 1'b1);
        for (int k = 0; k <= 6; k++) begin
            axi_wr(A_CLR, 32'h1, r);
            // all nibbles written before the next multiframe
            for (int j = 0; j < k; j++) begin
                seed = lfsr_next(seed);
                v = seed[3:0];
                if (j < 5) nib[j] = v;
                axi_wr(A_S, {28'h0, v}, r);
            end
            te_u.send_frame(got);
            chk(got, exp_s(nib, k));
            axi_rd(A_EVT, d, r);
            chk(d[st_mf_pkg::EVT_S_RDY], 1'b1);
        end
        $display("test s_transmit done");
        axi_wr(A_CLR, 32'h3, r);
        axi_wr(A_EN, 32'h2, r);
        te_u.send_q(4'h5);
        @(posedge aclk);
        chk(irq, 1'b1);
        axi_wr(A_EN, 32'h0, r);
        chk(irq, 1'b0);
        axi_wr(A_EN, 32'h2, r);
        chk(irq, 1'b1);
        // low byte lane off: the write must have no effect
        wstrb <= 4'he;
        axi_wr(A_EN, 32'h0, r);
        wstrb <= 4'hf;
        chk(r, st_mf_pkg::RESP_OKAY);
        chk(irq, 1'b1);
        axi_wr(A_CLR, 32'h2, r);
        chk(irq, 1'b0);
        axi_rd(A_EVT, d, r);
        chk(d[st_mf_pkg::EVT_NEW_Q], 1'b0);
        axi_wr(A_CTRL, 32'h0, r);
        axi_rd(A_Q, d, r);
        chk(d, 32'hf);
        $display("test interrupt done");
        end_sim();
    end
endmodule : test_st_multiframe_qs_buffer

`default_nettype wire
